// ===== irq_ctrl_regs.vh
`ifndef IRQ_CTRL_REGS_VH
`define IRQ_CTRL_REGS_VH

// Register word offsets on the plain register port
`define REG_ENABLE_SET 4'h0
`define REG_ENABLE_CLR 4'h1
`define REG_PEND_SET 4'h2
`define REG_PEND_CLR 4'h3
`define REG_ACTIVE 4'h4
`define REG_SYS_PRI 4'h5
`define REG_SYS_CTRL 4'h6
`define REG_STATUS 4'h7
`define REG_PRI_BASE 4'h8

// Priority field: two live bits at the top of each 8-bit lane
`define PRI_FIELD_W 8
`define PRI_MSB 7
`define PRI_LSB 6
`define PRI_RESET 2'h0

// System priority lanes in REG_SYS_PRI
`define SYS_PRI_SVC_LANE 0
`define SYS_PRI_PENDABLE_SERVICE_EXC_LANE 2
`define SYS_PRI_TICK_LANE 3

// REG_SYS_CTRL bits
`define CTRL_PENDABLE_SERVICE_EXC_SET 0
`define CTRL_PENDABLE_SERVICE_EXC_CLR 1
`define CTRL_TICK_SET 2
`define CTRL_TICK_CLR 3

// Vector numbers
`define VEC_RESET 6'h01
`define VEC_NMI 6'h02
`define VEC_HARD_FAULT 6'h03
`define VEC_SVC 6'h0B
`define VEC_PENDABLE_SERVICE_EXC 6'h0E
`define VEC_TICK 6'h0F
`define VEC_IRQ_BASE 6'h10

// Urgency ranks: fixed levels first, configurable levels offset past them
`define RANK_NMI 3'h1
`define RANK_HARD_FAULT 3'h2
`define RANK_CFG_OFFSET 3'h3
`define RANK_NONE 3'h7

// Lines that carry a real source; the rest are tied off
`define IRQ_IMPL_MASK 32'h7CD4FF3B

`define VTABLE_BASE 32'h00000000
`define STACK_FRAME_LAST 3'h7

`endif

// ===== irq_arbiter.v
module irq_arbiter #(
  parameter N = 48,
  parameter IW = 6,
  parameter RW = 3
) (
  input wire [N-1:0] req_i,
  input wire [N*RW-1:0] rank_i,
  output reg valid_o,
  output reg [IW-1:0] idx_o,
  output reg [RW-1:0] rank_o
);
  integer i;

  // Scan downward with <= so the lowest index wins a tie
  always @* begin
    valid_o = 1'b0;
    idx_o = {IW{1'b0}};
    rank_o = {RW{1'b1}};
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (req_i[i] && (rank_i[i*RW +: RW] <= rank_o || !valid_o)) begin
        valid_o = 1'b1;
        idx_o = i[IW-1:0];
        rank_o = rank_i[i*RW +: RW];
      end
    end
  end
endmodule

// ===== irq_ctrl.v
// Notes on behaviour
// - Thirty-two peripheral request lines, each with one of four priorities.
// - Priority value 0 is most urgent, value 3 least urgent.
// - All configurable priorities reset to level 0.
// - Reset, NMI, hard fault fixed above every configurable level.
// - Supervisor call 11, pendable service 14, tick 15; priorities configurable.
// - Peripheral line n uses vector n plus sixteen.
// - Preempt running handler only when new request is strictly more urgent.
// - Handler address fetched from vector table by hardware.
// - Push eight-word frame during vector fetch, pop it on return.
// - Pending request at handler end entered directly, no restore and resave.
// - More urgent arrival during entry switches target without restarting stacking.
// - Handlers run in handler mode entered through this controller.
// - Table base zero; word 0 stack pointer, word n handler.
// - Lines 0, 1, 3, 4, 5 carry brown-out, watchdog, pin, port groups.
// - Lines 8-15, 18, 20, 22, 23, 26, 27 carry timers, serials, bus, pulse.
// - Lines 28, 29, 30 carry wake-up, converter, clock-fail requests.
// - Write-one set and clear enable; both read current enable state.
// - Disabled line still pends but never activates; active stays active.
// - Write-one set and clear pending; clearing never touches active state.
// - Each priority is an 8-bit field, four per 32-bit register.
`include "irq_ctrl_regs.vh"

module irq_ctrl #(
  parameter NUM_IRQ = 32
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [NUM_IRQ-1:0] irq_lines_i,
  input wire nmi_i,
  input wire hard_fault_i,
  input wire svc_req_i,
  input wire tick_i,
  input wire exc_return_i,
  input wire [3:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  output reg mem_rd_o,
  output reg [31:0] mem_addr_o,
  input wire [31:0] mem_rdata_i,
  output reg stack_push_o,
  output reg stack_pop_o,
  output reg [2:0] stack_slot_o,
  output reg handler_entry_o,
  output reg [5:0] entry_vector_o,
  output reg [31:0] handler_addr_o,
  output reg [31:0] main_stack_pointer_o,
  output reg resume_o,
  output wire handler_mode_o
);
  localparam NV = 48;
  localparam S_BOOT0 = 3'h0;
  localparam S_BOOT1 = 3'h1;
  localparam S_BOOT2 = 3'h2;
  localparam S_RUN = 3'h3;
  localparam S_ENTRY = 3'h4;
  localparam S_RET = 3'h5;
  localparam S_UNSTACK = 3'h6;

  reg [2:0] state_reg;
  reg [NUM_IRQ-1:0] irq_en_reg;
  reg [NV-1:0] pend_reg;
  reg [NV-1:0] active_reg;
  reg [2*NUM_IRQ-1:0] irq_pri_reg;
  reg [1:0] svc_pri_reg;
  reg [1:0] pendable_service_exc_pri_reg;
  reg [1:0] tick_pri_reg;
  reg [5:0] sel_vec_reg;
  reg [2:0] sel_rank_reg;
  reg rd_wait_reg;
  reg fetched_reg;

  wire [NV*3-1:0] rank_bus;
  wire [NV-1:0] enabled;
  wire [NV-1:0] hw_src;
  wire [NV-1:0] sw_set;
  wire [NV-1:0] sw_clr;
  wire cand_valid, act_valid;
  wire [5:0] cand_vec, cur_vec;
  wire [2:0] cand_rank, act_rank, exec_rank;
  wire wr_pend_set, wr_pend_clr, wr_ctrl;
  wire late_win, entry_fin, do_return;

  function [2:0] cfg_rank;
    input [1:0] pri;
    begin
      cfg_rank = `RANK_CFG_OFFSET + {1'b0, pri};
    end
  endfunction

  function is_wr;
    input [3:0] off;
    begin
      is_wr = reg_wr_i && (reg_addr_i == off);
    end
  endfunction

  // Rank per vector; reserved vectors never request
  genvar g;
  generate
    for (g = 0; g < NV; g = g + 1) begin : g_rank
      if (g == 2) begin : g_nmi
        assign rank_bus[g*3 +: 3] = `RANK_NMI;
      end else if (g == 3) begin : g_hf
        assign rank_bus[g*3 +: 3] = `RANK_HARD_FAULT;
      end else if (g == 11) begin : g_svc
        assign rank_bus[g*3 +: 3] = cfg_rank(svc_pri_reg);
      end else if (g == 14) begin : g_psv
        assign rank_bus[g*3 +: 3] = cfg_rank(pendable_service_exc_pri_reg);
      end else if (g == 15) begin : g_tick
        assign rank_bus[g*3 +: 3] = cfg_rank(tick_pri_reg);
      end else if (g >= 16) begin : g_irq
        assign rank_bus[g*3 +: 3] = cfg_rank(irq_pri_reg[(g-16)*2 +: 2]);
      end else begin : g_none
        assign rank_bus[g*3 +: 3] = `RANK_NONE;
      end
    end
  endgenerate

  // System exceptions always enabled; peripheral lines gated by enable bits
  assign enabled = {irq_en_reg, 16'hC80C};
  // Tied-off lines cannot pend from hardware
  assign hw_src = {irq_lines_i & `IRQ_IMPL_MASK, tick_i, 3'h0, svc_req_i, 7'h00,
                   hard_fault_i, nmi_i, 2'h0};
  assign wr_pend_set = is_wr(`REG_PEND_SET);
  assign wr_pend_clr = is_wr(`REG_PEND_CLR);
  assign wr_ctrl = is_wr(`REG_SYS_CTRL);
  assign sw_set = {wr_pend_set ? reg_wdata_i : 32'h00000000,
                   wr_ctrl & reg_wdata_i[`CTRL_TICK_SET],
                   wr_ctrl & reg_wdata_i[`CTRL_PENDABLE_SERVICE_EXC_SET], 14'h0000};
  assign sw_clr = {wr_pend_clr ? reg_wdata_i : 32'h00000000,
                   wr_ctrl & reg_wdata_i[`CTRL_TICK_CLR],
                   wr_ctrl & reg_wdata_i[`CTRL_PENDABLE_SERVICE_EXC_CLR], 14'h0000};

  irq_arbiter #(
    .N(NV),
    .IW(6),
    .RW(3)
  ) u_pend_arb (
    .req_i(pend_reg & enabled),
    .rank_i(rank_bus),
    .valid_o(cand_valid),
    .idx_o(cand_vec),
    .rank_o(cand_rank)
  );

  // Innermost handler is the most urgent active one, since nesting is strict
  irq_arbiter #(
    .N(NV),
    .IW(6),
    .RW(3)
  ) u_act_arb (
    .req_i(active_reg),
    .rank_i(rank_bus),
    .valid_o(act_valid),
    .idx_o(cur_vec),
    .rank_o(act_rank)
  );

  assign exec_rank = act_valid ? act_rank : `RANK_NONE;
  assign handler_mode_o = act_valid;
  assign late_win = (state_reg == S_ENTRY) && cand_valid &&
                    (cand_rank < sel_rank_reg);
  assign entry_fin = (state_reg == S_ENTRY) && !stack_push_o && fetched_reg &&
                     !rd_wait_reg && !mem_rd_o && !late_win;
  assign do_return = (state_reg == S_RUN) && exc_return_i && act_valid;

  // Set wins over clear; activation consumes the pending bit
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      pend_reg <= {NV{1'b0}};
    end else begin
      pend_reg <= (pend_reg & ~sw_clr & ~(entry_fin ? ({{(NV-1){1'b0}}, 1'b1} << sel_vec_reg) :
                  {NV{1'b0}})) | hw_src | sw_set;
    end
  end

  // Disabling never touches active; only return or reset clears it
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      active_reg <= {NV{1'b0}};
    end else if (entry_fin) begin
      active_reg <= active_reg | ({{(NV-1){1'b0}}, 1'b1} << sel_vec_reg);
    end else if (do_return) begin
      active_reg <= active_reg & ~({{(NV-1){1'b0}}, 1'b1} << cur_vec);
    end
  end

  // Configuration registers
  integer k, m;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_en_reg <= {NUM_IRQ{1'b0}};
      irq_pri_reg <= {NUM_IRQ{`PRI_RESET}};
      svc_pri_reg <= `PRI_RESET;
      pendable_service_exc_pri_reg <= `PRI_RESET;
      tick_pri_reg <= `PRI_RESET;
    end else begin
      if (is_wr(`REG_ENABLE_SET)) begin
        irq_en_reg <= irq_en_reg | reg_wdata_i;
      end
      if (is_wr(`REG_ENABLE_CLR)) begin
        irq_en_reg <= irq_en_reg & ~reg_wdata_i;
      end
      if (is_wr(`REG_SYS_PRI)) begin
        svc_pri_reg <= reg_wdata_i[`SYS_PRI_SVC_LANE*8+`PRI_MSB -: 2];
        pendable_service_exc_pri_reg <= reg_wdata_i[`SYS_PRI_PENDABLE_SERVICE_EXC_LANE*8+`PRI_MSB -: 2];
        tick_pri_reg <= reg_wdata_i[`SYS_PRI_TICK_LANE*8+`PRI_MSB -: 2];
      end
      for (k = 0; k < NUM_IRQ; k = k + 1) begin
        if (reg_wr_i && (reg_addr_i == `REG_PRI_BASE + k[5:2])) begin
          irq_pri_reg[k*2 +: 2] <= reg_wdata_i[(k%4)*`PRI_FIELD_W+`PRI_LSB +: 2];
        end
      end
    end
  end

  // Read data stands in the cycle after the strobe only
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 32'h00000000;
    end else begin
      case (reg_addr_i)
        `REG_ENABLE_SET, `REG_ENABLE_CLR: reg_rdata_o <= irq_en_reg;
        `REG_PEND_SET, `REG_PEND_CLR: reg_rdata_o <= pend_reg[NV-1:16];
        `REG_ACTIVE: reg_rdata_o <= active_reg[NV-1:16];
        `REG_SYS_PRI: reg_rdata_o <= {tick_pri_reg, 6'h00, pendable_service_exc_pri_reg, 6'h00,
                                      8'h00, svc_pri_reg, 6'h00};
        `REG_SYS_CTRL: reg_rdata_o <= {27'h0000000, pend_reg[15], pend_reg[14],
                                       pend_reg[11], pend_reg[3], pend_reg[2]};
        `REG_STATUS: reg_rdata_o <= {13'h0000, exec_rank, 7'h00, act_valid,
                                     2'h0, cur_vec};
        default: begin
          if (reg_addr_i >= `REG_PRI_BASE) begin
            for (m = 0; m < 4; m = m + 1) begin
              reg_rdata_o[m*8 +: 8] <= {irq_pri_reg[((reg_addr_i-`REG_PRI_BASE)*4+m)*2 +: 2],
                                        6'h00};
            end
          end else begin
            reg_rdata_o <= 32'h00000000;
          end
        end
      endcase
    end
  end

  // Exception entry and return sequencer
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= S_BOOT0;
      mem_rd_o <= 1'b0;
      mem_addr_o <= `VTABLE_BASE;
      rd_wait_reg <= 1'b0;
      fetched_reg <= 1'b0;
      stack_push_o <= 1'b0;
      stack_pop_o <= 1'b0;
      stack_slot_o <= 3'h0;
      handler_entry_o <= 1'b0;
      entry_vector_o <= 6'h00;
      handler_addr_o <= 32'h00000000;
      main_stack_pointer_o <= 32'h00000000;
      resume_o <= 1'b0;
      sel_vec_reg <= 6'h00;
      sel_rank_reg <= `RANK_NONE;
    end else begin
      mem_rd_o <= 1'b0;
      rd_wait_reg <= mem_rd_o;
      handler_entry_o <= 1'b0;
      resume_o <= 1'b0;
      case (state_reg)
        S_BOOT0: begin
          mem_rd_o <= 1'b1;
          mem_addr_o <= `VTABLE_BASE;
          state_reg <= S_BOOT1;
        end
        S_BOOT1: begin
          if (rd_wait_reg) begin
            main_stack_pointer_o <= mem_rdata_i;
            mem_rd_o <= 1'b1;
            mem_addr_o <= `VTABLE_BASE + {24'h000000, `VEC_RESET, 2'h0};
            state_reg <= S_BOOT2;
          end
        end
        S_BOOT2: begin
          if (rd_wait_reg) begin
            handler_addr_o <= mem_rdata_i;
            entry_vector_o <= `VEC_RESET;
            handler_entry_o <= 1'b1;
            state_reg <= S_RUN;
          end
        end
        S_RUN: begin
          if (do_return) begin
            state_reg <= S_RET;
          end else if (cand_valid && cand_rank < exec_rank) begin
            sel_vec_reg <= cand_vec;
            sel_rank_reg <= cand_rank;
            mem_rd_o <= 1'b1;
            mem_addr_o <= `VTABLE_BASE + {24'h000000, cand_vec, 2'h0};
            fetched_reg <= 1'b0;
            stack_push_o <= 1'b1;
            stack_slot_o <= 3'h0;
            state_reg <= S_ENTRY;
          end
        end
        S_ENTRY: begin
          if (stack_push_o) begin
            if (stack_slot_o == `STACK_FRAME_LAST) begin
              stack_push_o <= 1'b0;
            end else begin
              stack_slot_o <= stack_slot_o + 3'h1;
            end
          end
          if (late_win) begin
            // Retarget; the frame push keeps going untouched
            sel_vec_reg <= cand_vec;
            sel_rank_reg <= cand_rank;
            mem_rd_o <= 1'b1;
            mem_addr_o <= `VTABLE_BASE + {24'h000000, cand_vec, 2'h0};
            fetched_reg <= 1'b0;
          end else if (rd_wait_reg && !mem_rd_o) begin
            handler_addr_o <= mem_rdata_i;
            fetched_reg <= 1'b1;
          end
          if (entry_fin) begin
            entry_vector_o <= sel_vec_reg;
            handler_entry_o <= 1'b1;
            state_reg <= S_RUN;
          end
        end
        S_RET: begin
          if (cand_valid && cand_rank < exec_rank) begin
            // Chain straight in; the saved frame is reused
            sel_vec_reg <= cand_vec;
            sel_rank_reg <= cand_rank;
            mem_rd_o <= 1'b1;
            mem_addr_o <= `VTABLE_BASE + {24'h000000, cand_vec, 2'h0};
            fetched_reg <= 1'b0;
            state_reg <= S_ENTRY;
          end else begin
            stack_pop_o <= 1'b1;
            stack_slot_o <= 3'h0;
            state_reg <= S_UNSTACK;
          end
        end
        S_UNSTACK: begin
          if (stack_slot_o == `STACK_FRAME_LAST) begin
            stack_pop_o <= 1'b0;
            resume_o <= 1'b1;
            state_reg <= S_RUN;
          end else begin
            stack_slot_o <= stack_slot_o + 3'h1;
          end
        end
        default: begin
          state_reg <= S_RUN;
        end
      endcase
    end
  end
endmodule

// ===== vector_table_model.sv
module vector_table_model (
  input wire logic clk_i,
  input wire logic rd_i,
  input wire logic [31:0] addr_i,
  output logic [31:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Word 0 is the stack pointer, word n the entry of vector n
  always @(posedge clk_i) begin
    if (!rd_i) begin
      rdata_o <= ~rdata_o; // Stale word must not look valid
    end else if (addr_i[7:2] == 6'h00) begin
      rdata_o <= 32'h20000400;
    end else begin
      rdata_o <= {24'h000001, addr_i[7:2], 2'h1};
    end
  end
endmodule

// ===== irq_ctrl_asserts.sv
module irq_ctrl_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic mem_rd_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic stack_push_o,
  input wire logic stack_pop_o,
  input wire logic [2:0] stack_slot_o,
  input wire logic handler_entry_o,
  input wire logic [5:0] entry_vector_o,
  input wire logic resume_o,
  input wire logic exc_return_i,
  input wire logic handler_mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_push8;
    stack_push_o [*8] ##1 !stack_push_o;
  endsequence
  sequence s_pop8;
    stack_pop_o [*8] ##1 !stack_pop_o;
  endsequence
  sequence s_tail;
    exc_return_i && handler_mode_o ##2 mem_rd_o;
  endsequence
  property p_rd_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0;
  endproperty
  property p_table_addr;
    mem_rd_o |-> mem_addr_o[31:8] == 24'h0 && mem_addr_o[1:0] == 2'h0;
  endproperty
  property p_entry_addr;
    handler_entry_o |-> mem_addr_o == {24'h0, entry_vector_o, 2'h0};
  endproperty
  property p_push_frame;
    $rose(stack_push_o) |-> stack_slot_o == 3'h0 ##0 s_push8;
  endproperty
  property p_slot_step;
    stack_push_o && $past(stack_push_o) |-> stack_slot_o == $past(stack_slot_o) + 3'h1;
  endproperty
  property p_pop_frame;
    $rose(stack_pop_o) |-> s_pop8 ##[0:2] resume_o;
  endproperty
  property p_fetch_entry;
    mem_rd_o |-> ##[1:12] handler_entry_o;
  endproperty
  property p_tail;
    s_tail |-> (!stack_push_o && !stack_pop_o) [*3];
  endproperty
  property p_entry_mode;
    // Boot entry runs the reset code in thread mode
    handler_entry_o && entry_vector_o != 6'h01 |=> handler_mode_o;
  endproperty
  property p_vec;
    handler_entry_o |-> entry_vector_o inside {6'h01, 6'h02, 6'h03, 6'h0B, 6'h0E, 6'h0F}
      || (entry_vector_o >= 6'h10 && entry_vector_o <= 6'h2F);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
  a_table_addr: assert property (p_table_addr) else $error("table address off base");
  a_entry_addr: assert property (p_entry_addr) else $error("entry not from its vector");
  a_push_frame: assert property (p_push_frame) else $error("push frame not eight words");
  a_slot_step: assert property (p_slot_step) else $error("push slot skipped");
  a_pop_frame: assert property (p_pop_frame) else $error("pop frame or resume wrong");
  a_fetch_entry: assert property (p_fetch_entry) else $error("fetch without entry");
  a_tail: assert property (p_tail) else $error("tail chain stacked");
  a_entry_mode: assert property (p_entry_mode) else $error("handler not in handler mode");
  a_vec: assert property (p_vec) else $error("reserved vector entered");
endmodule

bind irq_ctrl irq_ctrl_checker i_irq_ctrl_checker (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
  .stack_push_o(stack_push_o), .stack_pop_o(stack_pop_o), .stack_slot_o(stack_slot_o),
  .handler_entry_o(handler_entry_o), .entry_vector_o(entry_vector_o), .resume_o(resume_o),
  .exc_return_i(exc_return_i), .handler_mode_o(handler_mode_o));

// ===== tb_top.sv
`include "irq_ctrl_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [31:0] irq_lines_i = 32'h0;
  logic nmi_i = 1'b0, hard_fault_i = 1'b0, svc_req_i = 1'b0, tick_i = 1'b0, exc_return_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  wire [31:0] reg_rdata_o, mem_addr_o, mem_rdata_i, handler_addr_o, main_stack_pointer_o;
  wire mem_rd_o, stack_push_o, stack_pop_o, handler_entry_o, resume_o, handler_mode_o;
  wire [2:0] stack_slot_o;
  wire [5:0] entry_vector_o;
  int n_fail = 0, samples_checked = 0, n_push = 0, n_pop = 0;
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (stack_push_o === 1'b1) n_push++;
    if (stack_pop_o === 1'b1) n_pop++;
  end
  irq_ctrl #(.NUM_IRQ(32)) i_irq_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .irq_lines_i(irq_lines_i), .nmi_i(nmi_i), .hard_fault_i(hard_fault_i), .svc_req_i(svc_req_i),
    .tick_i(tick_i), .exc_return_i(exc_return_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
    .mem_rdata_i(mem_rdata_i), .stack_push_o(stack_push_o), .stack_pop_o(stack_pop_o),
    .stack_slot_o(stack_slot_o), .handler_entry_o(handler_entry_o),
    .entry_vector_o(entry_vector_o), .handler_addr_o(handler_addr_o),
    .main_stack_pointer_o(main_stack_pointer_o), .resume_o(resume_o),
    .handler_mode_o(handler_mode_o));
  vector_table_model i_vector_table_model (.clk_i(clk_i), .rd_i(mem_rd_o),
    .addr_i(mem_addr_o), .rdata_o(mem_rdata_i));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 check("register read", reg_rdata_o, exp);
  endtask
  // Codes 0..3 raise svc, hard fault, tick, nmi; 4 ends the handler
  task automatic fire(input int k);
    @(posedge clk_i);
    case (k)
      0: svc_req_i <= 1'b1;
      1: hard_fault_i <= 1'b1;
      2: tick_i <= 1'b1;
      3: nmi_i <= 1'b1;
      default: exc_return_i <= 1'b1;
    endcase
    @(posedge clk_i);
    {svc_req_i, hard_fault_i, tick_i, nmi_i, exc_return_i} <= 5'h0;
  endtask
  // Vector 0 means wait for resume; frame counts run from the previous wait
  task automatic wait_ev(input logic [5:0] v, input int np, input int npp);
    int i;
    for (i = 0; i < 60; i++) begin
      @(posedge clk_i);
      if (v != 6'h0 ? handler_entry_o === 1'b1 : resume_o === 1'b1) break;
    end
    if (i == 60) begin
      n_fail++;
      $display("unexpected timeout waiting for vector %0d", v);
      report_and_stop();
    end
    check("push count", n_push, np);
    check("pop count", n_pop, npp);
    if (v != 6'h0) begin
      check("entry vector", entry_vector_o, v);
      check("handler address", handler_addr_o, {24'h000001, v, 2'h1});
    end
    n_push = 0;
    n_pop = 0;
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clk_i);
      check("no entry", handler_entry_o, 1'b0);
    end
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    wait_ev(`VEC_RESET, 0, 0);
    check("stack pointer", main_stack_pointer_o, 32'h20000400);
    for (int j = 0; j < 8; j++) rdc(`REG_PRI_BASE | 4'(j), 32'h0);
    rdc(`REG_SYS_PRI, 32'h0);
    $display("test reset done");
    wr(`REG_ENABLE_SET, 32'h00007F00);
    wr(`REG_ENABLE_CLR, 32'h00006000);
    rdc(`REG_ENABLE_SET, 32'h00001F00);
    rdc(`REG_ENABLE_CLR, 32'h00001F00);
    wr(`REG_PRI_BASE | 4'h2, 32'hFFFFFFFF);
    rdc(`REG_PRI_BASE | 4'h2, 32'hC0C0C0C0);
    // Line 8 least urgent, 9 level 1, 11 level 0, 12 level 3
    wr(`REG_PRI_BASE | 4'h2, 32'h008040C0);
    wr(`REG_PRI_BASE | 4'h3, 32'h000000C0);
    rdc(`REG_PRI_BASE | 4'h2, 32'h008040C0);
    $display("test registers done");
    wr(`REG_PEND_SET, 32'h00000100);
    wait_ev(6'h18, 8, 0);
    wr(`REG_PEND_CLR, 32'h00000100);
    rdc(`REG_ACTIVE, 32'h00000100);
    wr(`REG_PEND_SET, 32'h00001000);
    quiet(30);
    wr(`REG_PEND_SET, 32'h00000200);
    wr(`REG_PEND_SET, 32'h00000800);
    wait_ev(6'h1B, 8, 0);
    rdc(`REG_ACTIVE, 32'h00000900);
    fire(4);
    wait_ev(6'h19, 0, 0);
    fire(4);
    wait_ev(6'h0, 0, 8);
    fire(4);
    wait_ev(6'h1C, 0, 0);
    fire(4);
    wait_ev(6'h0, 0, 8);
    check("handler mode", handler_mode_o, 1'b0);
    $display("test nesting done");
    @(posedge clk_i);
    irq_lines_i <= 32'h00002004;
    repeat (2) @(posedge clk_i);
    irq_lines_i <= 32'h0;
    quiet(20);
    rdc(`REG_PEND_SET, 32'h00002000);
    wr(`REG_PEND_CLR, 32'h00002000);
    rdc(`REG_PEND_SET, 32'h0);
    $display("test pending done");
    wr(`REG_SYS_PRI, 32'hFFFFFFFF);
    rdc(`REG_SYS_PRI, 32'hC0C000C0);
    fire(0);
    wait_ev(`VEC_SVC, 8, 0);
    fire(1);
    wait_ev(`VEC_HARD_FAULT, 8, 0);
    rdc(`REG_STATUS, 32'h00020103);
    // Tick stays pending under hard fault; set beats clear in one write
    wr(`REG_SYS_CTRL, (32'h1 << `CTRL_TICK_SET) | (32'h1 << `CTRL_TICK_CLR));
    rdc(`REG_SYS_CTRL, 32'h00000010);
    wr(`REG_SYS_CTRL, 32'h1 << `CTRL_TICK_CLR);
    rdc(`REG_SYS_CTRL, 32'h0);
    fire(4);
    wait_ev(6'h0, 0, 8);
    fire(4);
    wait_ev(6'h0, 0, 8);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) wr(`REG_SYS_CTRL, 32'h1 << `CTRL_PENDABLE_SERVICE_EXC_SET);
      else fire(k + 2);
      wait_ev(k == 0 ? `VEC_TICK : k == 1 ? `VEC_NMI : `VEC_PENDABLE_SERVICE_EXC, 8, 0);
      fire(4);
      wait_ev(6'h0, 0, 8);
    end
    $display("test exceptions done");
    // Lines 0 and 30 tie at level 0: lowest vector first, the other chains in
    wr(`REG_ENABLE_SET, 32'h40000001);
    @(posedge clk_i);
    irq_lines_i <= 32'h40000001;
    @(posedge clk_i);
    irq_lines_i <= 32'h0;
    wait_ev(6'h10, 8, 0);
    fire(4);
    wait_ev(6'h2E, 0, 0);
    fire(4);
    wait_ev(6'h0, 0, 8);
    $display("test lines done");
    report_and_stop();
  end
endmodule
